// *** tmr_regs.svh ***
// Purpose: register offsets, field positions, reset values and timing counts of the timer block
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes: definitions only
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH
`define TMR_OFF_COUNT 12'h000
`define TMR_OFF_COMPARE 12'h004
`define TMR_OFF_IMASK 12'h008
`define TMR_OFF_IFLAGS 12'h00c
`define TMR_OFF_SFC 12'h010
`define TMR_OFF_CTRL 12'h014
`define TMR_OFF_GLOBAL 12'h018
`define TMR_OFF_STATUS 12'h01c
`define TMR_BIT_OVF 0
`define TMR_BIT_CMP 1
`define TMR_BIT_PSR 0
`define TMR_BIT_GIE 0
`define TMR_CTRL_CS_LSB 0
`define TMR_CTRL_PC_BIT 3
`define TMR_RST_BYTE 8'h00
`define TMR_RST_CS 3'h0
`define TMR_PRE_W 10
`define TMR_DIV8_MASK 10'h007
`define TMR_DIV64_MASK 10'h03f
`define TMR_DIV256_MASK 10'h0ff
`define TMR_DIV1024_MASK 10'h3ff
`endif

// *** tmr_pkg.sv ***
// Purpose: types shared by the timer block
// Assumes: nothing
// Notes: constants live in tmr_regs.svh
package tmr_pkg;
    typedef enum logic [2:0] {
        TMR_CS_STOP,
        TMR_CS_DIV1,
        TMR_CS_DIV8,
        TMR_CS_DIV64,
        TMR_CS_DIV256,
        TMR_CS_DIV1024,
        TMR_CS_EXT_FALL,
        TMR_CS_EXT_RISE
    } tmr_cs_type;
    typedef enum logic {
        TMR_DIR_UP,
        TMR_DIR_DOWN
    } tmr_dir_type;
endpackage

// *** tmr_timer0.sv ***
// Purpose: 8-bit timer counter, compare, flags and shared free-running prescaler
// Assumes: APB slave, one 125 MHz clock, external pin asynchronous
// Notes: waveform modes beyond normal and phase-correct counting are not built here
// Summary of operation
// - software reads and writes count any time
// - count write blocks next tick's compare match
// - compare value continuously compared with count
// - mask bit 1 enables compare interrupt
// - mask bit 0 enables overflow interrupt
// - compare flag set on match, cleared
// - overflow flag set on overflow, cleared
// - phase-correct sets overflow at zero turn
// - one prescaler shared, separate selections
// - select one counts every system clock
// - prescaler taps divide 8,64,256,1024
// - select field encoding stop/div/ext edges
// - prescaler runs freely regardless of selection
// - first tapped tick within 1..N+1 clocks
// - prescaler reset restarts all timers' period
// - pin synchronised then edge detected
// - flops on rising edge, no latch
// - edge detector ticks per selected edge
// - pin edge reaches counter in ~3 clocks
// - external pin clock never prescaled
// - prescaler reset bit self-clears, reads zero
//
// The register offsets and the APB register port are this design's own decisions.
`include "tmr_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tmr_timer0 (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic externalCountPin,
    input wire logic [2:0] timer1ClockSelect,
    input wire logic compareVectorAck,
    input wire logic overflowVectorAck,
    output logic compareIrq,
    output logic overflowIrq,
    output logic compareMatchPulse,
    output logic timer1Tick,
    output logic prescalerClear
);
    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic tapTick(input logic [2:0] cs, input logic [9:0] pre,
                                     input logic extRise, input logic extFall);
        logic t;
        t = 1'b0;
        case (tmr_pkg::tmr_cs_type'(cs))
            tmr_pkg::TMR_CS_STOP: t = 1'b0;
            tmr_pkg::TMR_CS_DIV1: t = 1'b1;
            tmr_pkg::TMR_CS_DIV8: t = (pre & `TMR_DIV8_MASK) == `TMR_DIV8_MASK;
            tmr_pkg::TMR_CS_DIV64: t = (pre & `TMR_DIV64_MASK) == `TMR_DIV64_MASK;
            tmr_pkg::TMR_CS_DIV256: t = (pre & `TMR_DIV256_MASK) == `TMR_DIV256_MASK;
            tmr_pkg::TMR_CS_DIV1024: t = (pre & `TMR_DIV1024_MASK) == `TMR_DIV1024_MASK;
            tmr_pkg::TMR_CS_EXT_FALL: t = extFall;
            tmr_pkg::TMR_CS_EXT_RISE: t = extRise;
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // shared free-running prescaler
    logic [9:0] pre_q;
    logic [9:0] pre_d;
    // pin synchroniser and edge history
    logic sync1_q;
    logic sync1_d;
    logic sync2_q;
    logic sync2_d;
    logic pinPrev_q;
    logic pinPrev_d;
    // software visible timer state
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic [7:0] compare_q;
    logic [7:0] compare_d;
    logic [7:0] mask_q;
    logic [7:0] mask_d;
    logic cmpFlag_q;
    logic cmpFlag_d;
    logic ovfFlag_q;
    logic ovfFlag_d;
    logic gie_q;
    logic gie_d;
    logic [2:0] cs_q;
    logic [2:0] cs_d;
    logic pcMode_q;
    logic pcMode_d;
    tmr_pkg::tmr_dir_type dir_q;
    tmr_pkg::tmr_dir_type dir_d;
    // set by a count write, dropped by the next tick
    logic blockCmp_q;
    logic blockCmp_d;
    logic psrPulse_q;
    logic psrPulse_d;
    // bus answer
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    // registered outputs
    logic cmpIrq_q;
    logic cmpIrq_d;
    logic ovfIrq_q;
    logic ovfIrq_d;
    logic cmpPulse_q;
    logic cmpPulse_d;
    logic t1Tick_q;
    logic t1Tick_d;
    logic [2:0] t1Cs_q;
    logic [2:0] t1Cs_d;

    // decoded strobes and events
    logic wrStb;
    logic rdStb;
    logic addrOk;
    logic extRise;
    logic extFall;
    logic tick0;
    logic match;
    logic wrCount;
    logic wrCompare;
    logic wrMask;
    logic wrFlags;
    logic wrSfc;
    logic wrCtrl;
    logic wrGlobal;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    always_comb begin
        wrStb = psel && penable && pwrite && !pready_q;
        rdStb = psel && penable && !pwrite && !pready_q;
        addrOk = (paddr == `TMR_OFF_COUNT) || (paddr == `TMR_OFF_COMPARE) ||
                 (paddr == `TMR_OFF_IMASK) || (paddr == `TMR_OFF_IFLAGS) ||
                 (paddr == `TMR_OFF_SFC) || (paddr == `TMR_OFF_CTRL) ||
                 (paddr == `TMR_OFF_GLOBAL) || (paddr == `TMR_OFF_STATUS);
        wrCount = wrStb && paddr == `TMR_OFF_COUNT;
        wrCompare = wrStb && paddr == `TMR_OFF_COMPARE;
        wrMask = wrStb && paddr == `TMR_OFF_IMASK;
        wrFlags = wrStb && paddr == `TMR_OFF_IFLAGS;
        wrSfc = wrStb && paddr == `TMR_OFF_SFC;
        wrCtrl = wrStb && paddr == `TMR_OFF_CTRL;
        wrGlobal = wrStb && paddr == `TMR_OFF_GLOBAL;
    end

    // ------------------------------------------------------------
    // prescaler, pin synchroniser and tick selection
    // ------------------------------------------------------------
    always_comb begin
        psrPulse_d = wrSfc && pwdata[`TMR_BIT_PSR];
        pre_d = psrPulse_q ? 10'h000 : pre_q + 10'h001;
        // sampling on rising edges replaces the half-cycle latch; delay lands at ~3 clocks
        sync1_d = externalCountPin;
        sync2_d = sync1_q;
        pinPrev_d = sync2_q;
        extRise = sync2_q && !pinPrev_q;
        extFall = !sync2_q && pinPrev_q;
        // taps reach all-ones once per period: first tick 1..N+1 clocks after start
        tick0 = tapTick(cs_q, pre_q, extRise, extFall);
        t1Cs_d = timer1ClockSelect;
        t1Tick_d = tapTick(t1Cs_q, pre_q, extRise, extFall);
    end

    // ------------------------------------------------------------
    // counter, compare and flags
    // ------------------------------------------------------------
    always_comb begin
        match = count_q == compare_q;
        count_d = count_q;
        dir_d = dir_q;
        ovfFlag_d = ovfFlag_q;
        cmpFlag_d = cmpFlag_q;
        blockCmp_d = blockCmp_q;
        cmpPulse_d = 1'b0;
        if (tick0) begin
            blockCmp_d = 1'b0;
        end
        if (wrFlags && pwdata[`TMR_BIT_OVF]) begin
            ovfFlag_d = 1'b0;
        end
        if (wrFlags && pwdata[`TMR_BIT_CMP]) begin
            cmpFlag_d = 1'b0;
        end
        if (overflowVectorAck) begin
            ovfFlag_d = 1'b0;
        end
        if (compareVectorAck) begin
            cmpFlag_d = 1'b0;
        end
        if (tick0 && match && !blockCmp_q) begin
            cmpFlag_d = 1'b1;
            cmpPulse_d = 1'b1;
        end
        if (tick0) begin
            if (!pcMode_q) begin
                count_d = count_q + 8'h01;
                dir_d = tmr_pkg::TMR_DIR_UP;
                if (count_q == 8'hff) begin
                    ovfFlag_d = 1'b1;
                end
            end else if (dir_q == tmr_pkg::TMR_DIR_UP) begin
                if (count_q == 8'hff) begin
                    dir_d = tmr_pkg::TMR_DIR_DOWN;
                    count_d = 8'hfe;
                end else begin
                    count_d = count_q + 8'h01;
                end
            end else if (count_q == 8'h00) begin
                dir_d = tmr_pkg::TMR_DIR_UP;
                count_d = 8'h01;
                ovfFlag_d = 1'b1;
            end else begin
                count_d = count_q - 8'h01;
            end
        end
        if (wrCount) begin
            count_d = pwdata[7:0];
            blockCmp_d = 1'b1;
        end
        compare_d = wrCompare ? pwdata[7:0] : compare_q;
        mask_d = wrMask ? pwdata[7:0] : mask_q;
        cs_d = wrCtrl ? pwdata[`TMR_CTRL_CS_LSB +: 3] : cs_q;
        pcMode_d = wrCtrl ? pwdata[`TMR_CTRL_PC_BIT] : pcMode_q;
        gie_d = wrGlobal ? pwdata[`TMR_BIT_GIE] : gie_q;
        cmpIrq_d = gie_q && mask_q[`TMR_BIT_CMP] && cmpFlag_q;
        ovfIrq_d = gie_q && mask_q[`TMR_BIT_OVF] && ovfFlag_q;
    end

    // ------------------------------------------------------------
    // read data and handshake
    // ------------------------------------------------------------
    always_comb begin
        pready_d = psel && penable && !pready_q;
        pslverr_d = psel && penable && !pready_q && !addrOk;
        prdata_d = 32'h0000_0000;
        if (rdStb) begin
            case (paddr)
                `TMR_OFF_COUNT: prdata_d = {24'h000000, count_q};
                `TMR_OFF_COMPARE: prdata_d = {24'h000000, compare_q};
                `TMR_OFF_IMASK: prdata_d = {24'h000000, mask_q};
                `TMR_OFF_IFLAGS: prdata_d = {30'h00000000, cmpFlag_q, ovfFlag_q};
                `TMR_OFF_SFC: prdata_d = 32'h0000_0000;
                `TMR_OFF_CTRL: prdata_d = {28'h0000000, pcMode_q, cs_q};
                `TMR_OFF_GLOBAL: prdata_d = {31'h00000000, gie_q};
                `TMR_OFF_STATUS: prdata_d = {31'h00000000, dir_q == tmr_pkg::TMR_DIR_DOWN};
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pre_q <= 10'h000;
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            pinPrev_q <= 1'b0;
            count_q <= `TMR_RST_BYTE;
            compare_q <= `TMR_RST_BYTE;
            mask_q <= `TMR_RST_BYTE;
            cmpFlag_q <= 1'b0;
            ovfFlag_q <= 1'b0;
            gie_q <= 1'b0;
            cs_q <= `TMR_RST_CS;
            pcMode_q <= 1'b0;
            dir_q <= tmr_pkg::TMR_DIR_UP;
            blockCmp_q <= 1'b0;
            psrPulse_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            cmpIrq_q <= 1'b0;
            ovfIrq_q <= 1'b0;
            cmpPulse_q <= 1'b0;
            t1Tick_q <= 1'b0;
            t1Cs_q <= `TMR_RST_CS;
        end else begin
            pre_q <= pre_d;
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            pinPrev_q <= pinPrev_d;
            count_q <= count_d;
            compare_q <= compare_d;
            mask_q <= mask_d;
            cmpFlag_q <= cmpFlag_d;
            ovfFlag_q <= ovfFlag_d;
            gie_q <= gie_d;
            cs_q <= cs_d;
            pcMode_q <= pcMode_d;
            dir_q <= dir_d;
            blockCmp_q <= blockCmp_d;
            psrPulse_q <= psrPulse_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            cmpIrq_q <= cmpIrq_d;
            ovfIrq_q <= ovfIrq_d;
            cmpPulse_q <= cmpPulse_d;
            t1Tick_q <= t1Tick_d;
            t1Cs_q <= t1Cs_d;
        end
    end

    always_comb begin
        prdata = prdata_q;
        pready = pready_q;
        pslverr = pslverr_q;
        compareIrq = cmpIrq_q;
        overflowIrq = ovfIrq_q;
        compareMatchPulse = cmpPulse_q;
        timer1Tick = t1Tick_q;
        prescalerClear = psrPulse_q;
    end
endmodule
`default_nettype wire

// *** tmr_timer0_sva.sv ***
// Purpose: port checks of tmr_timer0
// Assumes: one clock, APB with one wait state
// Notes: bound to the design below
`include "tmr_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tmr_timer0_sva (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic externalCountPin,
    input wire logic [2:0] timer1ClockSelect,
    input wire logic timer1Tick,
    input wire logic prescalerClear
);
    // ----------------
    // checks
    // ----------------
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    wire take = psel && penable && !pready;
    wait_state_a: assert property (take |=> pready)
        else $error("ready late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held");
    psr_start_a: assert property (take && pwrite && paddr == `TMR_OFF_SFC
        && pwdata[0] |-> ##[1:2] prescalerClear) else $error("no clear");
    psr_once_a: assert property (prescalerClear |=> !prescalerClear)
        else $error("clear held");
    tick_single_a: assert property (timer1ClockSelect inside {[3'h2:3'h5]}
        && timer1Tick |=> !timer1Tick) else $error("long tick");
    full_rate_a: assert property (timer1ClockSelect == 3'h1 [*3] |-> timer1Tick)
        else $error("no full rate tick");
    tap_restart_a: assert property (timer1ClockSelect == 3'h2 && prescalerClear
        |-> ##2 !timer1Tick [*5]) else $error("tap not restarted");
    pin_rise_a: assert property ($rose(externalCountPin)
        && timer1ClockSelect == 3'h7 |-> ##[2:4] timer1Tick) else $error("pin tick late");
    cover property (prescalerClear);
    cover property (timer1Tick && timer1ClockSelect == 3'h7);
    cover property (timer1Tick && timer1ClockSelect == 3'h5);
endmodule
bind tmr_timer0 tmr_timer0_sva CHK (.*);
`default_nettype wire

// *** tmr_pulse_src.sv ***
// Purpose: external count pulse source
// Assumes: pin sampled by the system clock
// Notes: pin rests low while disabled
`timescale 1ns/1ps
`default_nettype none
module tmr_pulse_src #(parameter int HALF = 3) (
    input wire logic clock,
    input wire logic enable,
    output logic pin
);
    int cnt = 0;
    initial pin = 1'b0;
    // half period of HALF clocks, kept above one
    always @(posedge clock) begin
        if (!enable) begin
            pin <= 1'b0;
            cnt <= 0;
        end else if (cnt == HALF - 1) begin
            pin <= ~pin;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule
`default_nettype wire

// *** tb_tmr_timer0.sv ***
// Purpose: register and tick tests of tmr_timer0
// Assumes: APB with one wait state
// Notes: pin driven by tmr_pulse_src
`include "tmr_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_tmr_timer0;
    logic clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, se;
    logic pready, pslverr, extPin, cmpIrq, ovfIrq, t1Tick;
    logic [2:0] t1Sel = 3'h0;
    logic srcOn = 1'b0;
    int err_total = 0, tests_run = 0, cyc = 0, n, pulses = 0;
    logic cmpPulse;
    int dv[4] = '{8, 64, 256, 1024};
    tmr_timer0 DUT (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .externalCountPin(extPin), .timer1ClockSelect(t1Sel),
        .compareVectorAck(1'b0), .overflowVectorAck(1'b0), .compareIrq(cmpIrq),
        .overflowIrq(ovfIrq), .compareMatchPulse(cmpPulse), .timer1Tick(t1Tick),
        .prescalerClear());
    tmr_pulse_src #(.HALF(3)) SRC (.clock(clock), .enable(srcOn), .pin(extPin));
    // ----------------
    // tasks
    // ----------------
    task automatic test_done();
        $display("errors %0d checks %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
        end
        rd = prdata;
        se = 32'(pslverr);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        wr(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    initial forever #4 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cmpPulse === 1'b1) begin
            pulses <= pulses + 1;
        end
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        rdchk(`TMR_OFF_IMASK, 32'h0);
        wr(1'b1, `TMR_OFF_COUNT, 32'ha5);
        rdchk(`TMR_OFF_COUNT, 32'ha5);
        wr(1'b1, `TMR_OFF_COMPARE, 32'h10);
        rdchk(`TMR_OFF_COMPARE, 32'h10);
        rdchk(12'h020, 32'h0);
        chk(se, 32'h1);
        wr(1'b1, `TMR_OFF_SFC, 32'h1);
        rdchk(`TMR_OFF_SFC, 32'h0);
        t1Sel <= 3'h1;
        wr(1'b1, `TMR_OFF_COUNT, 32'hfe);
        wr(1'b1, `TMR_OFF_CTRL, 32'h1);
        repeat (8) @(posedge clock);
        wr(1'b1, `TMR_OFF_CTRL, 32'h0);
        rdchk(`TMR_OFF_IFLAGS, 32'h1);
        wr(1'b1, `TMR_OFF_GLOBAL, 32'h1);
        wr(1'b1, `TMR_OFF_IMASK, 32'h3);
        chk(32'(ovfIrq), 32'h1);
        wr(1'b1, `TMR_OFF_IFLAGS, 32'h0);
        rdchk(`TMR_OFF_IFLAGS, 32'h1);
        wr(1'b1, `TMR_OFF_IFLAGS, 32'h1);
        rdchk(`TMR_OFF_IFLAGS, 32'h0);
        chk(32'(ovfIrq), 32'h0);
        wr(1'b1, `TMR_OFF_COUNT, 32'h0);
        wr(1'b1, `TMR_OFF_CTRL, 32'h1);
        repeat (24) @(posedge clock);
        wr(1'b1, `TMR_OFF_CTRL, 32'h0);
        rdchk(`TMR_OFF_IFLAGS, 32'h2);
        chk(32'(cmpIrq), 32'h1);
        t1Sel <= 3'h0;
        wr(1'b1, `TMR_OFF_IFLAGS, 32'h2);
        wr(1'b1, `TMR_OFF_CTRL, 32'h2);
        wr(1'b1, `TMR_OFF_COUNT, 32'h10);
        repeat (10) @(posedge clock);
        wr(1'b1, `TMR_OFF_CTRL, 32'h0);
        rdchk(`TMR_OFF_IFLAGS, 32'h0);
        chk(32'(pulses), 32'h1);
        for (int i = 0; i < 4; i++) begin
            t1Sel <= 3'(i + 2);
            wr(1'b1, `TMR_OFF_COUNT, 32'h0);
            wr(1'b1, `TMR_OFF_SFC, 32'h1);
            wr(1'b1, `TMR_OFF_CTRL, 32'(i + 2));
            repeat (4 * dv[i]) @(posedge clock);
            wr(1'b1, `TMR_OFF_CTRL, 32'h0);
            wr(1'b0, `TMR_OFF_COUNT, 32'h0);
            chk(32'(rd inside {[3:5]}), 32'h1);
        end
        for (int i = 0; i < 2; i++) begin
            t1Sel <= 3'(7 - i);
            wr(1'b1, `TMR_OFF_COUNT, 32'h0);
            wr(1'b1, `TMR_OFF_CTRL, 32'(7 - i));
            srcOn <= 1'b1;
            repeat (60) @(posedge clock);
            srcOn <= 1'b0;
            repeat (8) @(posedge clock);
            wr(1'b1, `TMR_OFF_CTRL, 32'h0);
            wr(1'b0, `TMR_OFF_COUNT, 32'h0);
            chk(32'(rd inside {[9:11]}), 32'h1);
        end
        wr(1'b1, `TMR_OFF_IFLAGS, 32'h3);
        wr(1'b1, `TMR_OFF_COUNT, 32'h5);
        wr(1'b1, `TMR_OFF_CTRL, 32'h9);
        repeat (300) @(posedge clock);
        wr(1'b0, `TMR_OFF_IFLAGS, 32'h0);
        chk(32'(rd[0]), 32'h0);
        repeat (300) @(posedge clock);
        wr(1'b0, `TMR_OFF_IFLAGS, 32'h0);
        chk(32'(rd[0]), 32'h1);
        test_done();
    end
endmodule
`default_nettype wire
